/* hw/uhbp_pkg.sv */
// constants for the uart host bus port
package uhbp_pkg;
  localparam int DATA_W   = 8;
  localparam int ADDR_W   = 3;
  localparam int NUM_REGS = 8;
  localparam int SYNC_LEN = 3;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] ADDR_RESET = 3'h0;
endpackage

/* hw/uhbp_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module uhbp_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk,    // system clock
  input  wire logic rst_n,  // async reset, active low
  input  wire logic pinIn,  // raw pin level
  output logic      level   // filtered level
);
  logic s1Reg;
  logic s2Reg;
  logic s3Reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1Reg <= RESET_VAL;
      s2Reg <= RESET_VAL;
      s3Reg <= RESET_VAL;
    end else begin
      s1Reg <= pinIn;
      s2Reg <= s1Reg;
      s3Reg <= s2Reg;
    end
  end
  // change counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= RESET_VAL;
    end else if (s2Reg == s3Reg) begin
      level <= s3Reg;
    end
  end
endmodule
`default_nettype wire

/* hw/uhbp_host_port.sv */
// host parallel bus port with eight internal byte registers
`timescale 1ns/1ps
`default_nettype none
module uhbp_host_port
  import uhbp_pkg::*;
(
  input  wire logic              clk,               // 10 MHz clock
  input  wire logic              rst_n,             // async reset, low
  input  wire logic              unitReset,         // unit reset, high
  input  wire logic [ADDR_W-1:0] regAddr,           // register address
  input  wire logic              selectAHi,         // select a, high
  input  wire logic              selectBHi,         // select b, high
  input  wire logic              selectCLo_n,       // select c, low
  input  wire logic              addrLatchStrobe_n, // address strobe
  input  wire logic              readStrobeHi,      // read, high
  input  wire logic              readStrobeLo_n,    // read, low
  input  wire logic              writeStrobeHi,     // write, high
  input  wire logic              writeStrobeLo_n,   // write, low
  input  wire logic [DATA_W-1:0] hostDataIn,        // bus level seen
  output logic      [DATA_W-1:0] hostDataOut,       // read data
  output logic                   hostDataOe,        // bus drive enable
  output logic                   selectedIndicator, // selected, high
  output logic                   driveDisable_n,    // low during read
  output logic      [DATA_W-1:0] regView [NUM_REGS] // register contents
);
  localparam int NSYNC = ADDR_W + 9;
  // each stage resets to its pin's idle level except the address strobe, reset low so no false fall follows reset
  localparam logic [NSYNC-1:0] SYNC_RST = {1'b0, 1'b1, 1'b0, 1'b1, 1'b0,
                                           1'b0, 1'b1, 1'b0, 1'b0,
                                           ADDR_RESET};
  logic [NSYNC-1:0] rawPins;
  logic [NSYNC-1:0] syncPins;
  logic [DATA_W-1:0] dataSync;

  assign rawPins = {unitReset, writeStrobeLo_n, writeStrobeHi,
                    readStrobeLo_n, readStrobeHi, addrLatchStrobe_n,
                    selectCLo_n, selectBHi, selectAHi, regAddr};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : gSyncCtl
      uhbp_sync #(.RESET_VAL(SYNC_RST[gi])) uSync (
        .clk   (clk),
        .rst_n (rst_n),
        .pinIn (rawPins[gi]),
        .level (syncPins[gi])
      );
    end
    for (gi = 0; gi < DATA_W; gi++) begin : gSyncData
      uhbp_sync #(.RESET_VAL(1'b0)) uSync (
        .clk   (clk),
        .rst_n (rst_n),
        .pinIn (hostDataIn[gi]),
        .level (dataSync[gi])
      );
    end
  endgenerate

  logic [ADDR_W-1:0] addrS;
  logic selA;
  logic selB;
  logic selCn;
  logic asN;
  logic rdHi;
  logic rdLoN;
  logic wrHi;
  logic wrLoN;
  logic rstHi;
  assign addrS = syncPins[ADDR_W-1:0];
  assign selA  = syncPins[ADDR_W];
  assign selB  = syncPins[ADDR_W+1];
  assign selCn = syncPins[ADDR_W+2];
  assign asN   = syncPins[ADDR_W+3];
  assign rdHi  = syncPins[ADDR_W+4];
  assign rdLoN = syncPins[ADDR_W+5];
  assign wrHi  = syncPins[ADDR_W+6];
  assign wrLoN = syncPins[ADDR_W+7];
  assign rstHi = syncPins[ADDR_W+8];

  // address strobe latch: transparent while high, frozen at its fall
  logic              asPrevReg;
  logic [ADDR_W-1:0] addrLatReg;
  logic [2:0]        selLatReg;
  logic              asFall;
  assign asFall = asPrevReg && !asN;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      asPrevReg  <= 1'b0;
      addrLatReg <= ADDR_RESET;
      selLatReg  <= 3'h4;
    end else begin
      asPrevReg <= asN;
      if (rstHi) begin
        addrLatReg <= ADDR_RESET;
        selLatReg  <= 3'h4;
      end else if (asN || asFall) begin
        addrLatReg <= addrS;
        selLatReg  <= {selCn, selB, selA};
      end
    end
  end

  // capture stays in force from the strobe's fall until it rises again
  logic capValidReg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capValidReg <= 1'b0;
    end else if (rstHi) begin
      capValidReg <= 1'b0;
    end else if (asFall) begin
      capValidReg <= 1'b1;
    end else if (asN) begin
      capValidReg <= 1'b0;
    end
  end

  // live pins unless a fall captured them; tied low from reset stays live
  logic              useLive;
  logic [ADDR_W-1:0] effAddr;
  logic              selected;
  logic              rdAct;
  logic              wrAct;
  assign useLive  = asN || !capValidReg;
  assign effAddr  = useLive ? addrS : addrLatReg;
  assign selected = useLive ? (selA && selB && !selCn)
                            : (selLatReg == 3'h3);
  assign rdAct = selected && (rdHi || !rdLoN);
  assign wrAct = selected && (wrHi || !wrLoN);

  // register file, bit 0 of the bus is bit 0 of each register
  logic [DATA_W-1:0] regMem [NUM_REGS];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_REGS; i++) regMem[i] <= REG_RESET;
    end else if (rstHi) begin
      for (int i = 0; i < NUM_REGS; i++) regMem[i] <= REG_RESET;
    end else if (wrAct && !rdAct) begin
      regMem[effAddr] <= dataSync;
    end
  end
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) regView[i] = regMem[i];
  end

  // bus drive and indicator outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hostDataOut       <= REG_RESET;
      hostDataOe        <= 1'b0;
      selectedIndicator <= 1'b0;
      driveDisable_n    <= 1'b1;
    end else if (rstHi) begin
      hostDataOut       <= REG_RESET;
      hostDataOe        <= 1'b0;
      selectedIndicator <= 1'b0;
      driveDisable_n    <= 1'b1;
    end else begin
      hostDataOut       <= rdAct ? regMem[effAddr] : REG_RESET;
      hostDataOe        <= rdAct;
      selectedIndicator <= selected;
      driveDisable_n    <= !rdAct;
    end
  end

  // checks
  sequence readReq;
    selected && (rdHi || !rdLoN) && !rstHi;
  endsequence
  sequence driveOn;
    hostDataOe && !driveDisable_n;
  endsequence

  property readDrives;
    @(posedge clk) disable iff (!rst_n) readReq |=> driveOn;
  endproperty
  read_drive_a: assert property (readDrives)
    else $error("read strobe did not drive bus");

  bus_idle_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !rdAct |=> !hostDataOe)
    else $error("bus driven without read");

  unselected_quiet_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !selected && !rstHi |=> !hostDataOe && $stable(regMem[0]))
    else $error("unselected access acted");

  write_store_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    wrAct && !rdAct && !rstHi |=> regMem[$past(effAddr)] == $past(dataSync))
    else $error("write did not store data");

  select_ind_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !rstHi |=> selectedIndicator == $past(selected))
    else $error("indicator wrong");

  drive_disable_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !rstHi |=> driveDisable_n == !$past(rdAct))
    else $error("drive disable mismatch");

  unit_reset_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    rstHi |=> regMem[7] == REG_RESET && !hostDataOe)
    else $error("unit reset ignored");

  latch_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !asN && !asFall && !rstHi |=> $stable(addrLatReg))
    else $error("latched address changed");

  select_decode_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    asN && selA && selB && !selCn |-> selected)
    else $error("select decode wrong");

  latch_capture_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    asFall && !rstHi |=> selLatReg == $past({selCn, selB, selA}))
    else $error("selects not captured at strobe fall");

  read_data_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    rdAct && !rstHi |=> hostDataOut == $past(regMem[effAddr]))
    else $error("read data not from addressed register");
endmodule
`default_nettype wire

/* tb/uhbp_host_model.sv */
// host side model that resolves the shared data lines
`timescale 1ns/1ps
`default_nettype none
module uhbp_host_model
  import uhbp_pkg::*;
(
  input  wire logic              clk,      // system clock
  input  wire logic [DATA_W-1:0] devData,  // device drive value
  input  wire logic              devOe,    // device drives bus
  input  wire logic [DATA_W-1:0] hostData, // host drive value
  input  wire logic              hostOe,   // host drives bus
  output logic      [DATA_W-1:0] busLevel  // resolved bus level
);
  logic [DATA_W-1:0] lastReg = 8'h00;
  always_ff @(posedge clk) begin
    lastReg <= busLevel;
  end
  // released bus toggles so no stale value survives
  always_comb begin
    if (devOe) begin
      busLevel = devData;
    end else if (hostOe) begin
      busLevel = hostData;
    end else begin
      busLevel = ~lastReg;
    end
  end
endmodule
`default_nettype wire

/* tb/uart_host_bus_port_test.sv */
// self-checking bench for the host bus port
`timescale 1ns/1ps
`default_nettype none
module uart_host_bus_port_test;
  import uhbp_pkg::*;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              unitReset = 1'b0;
  logic [ADDR_W-1:0] regAddr = 3'h0;
  logic [2:0]        sel = 3'h1;
  logic              addrStrobe_n = 1'b1;
  logic              rdHi = 1'b0;
  logic              rdLo_n = 1'b1;
  logic              wrHi = 1'b0;
  logic              wrLo_n = 1'b1;
  logic [DATA_W-1:0] hostData = 8'h00;
  logic              hostOe = 1'b0;
  logic [DATA_W-1:0] busLevel;
  logic [DATA_W-1:0] devData;
  logic              devOe;
  logic              selInd;
  logic              drvDis_n;
  logic [DATA_W-1:0] regView [NUM_REGS];
  int                nErrors = 0;
  int                nTests = 0;
  always #50 clk = ~clk;
  uhbp_host_port i_uhbp_host_port (.clk(clk), .rst_n(rst_n),
    .unitReset(unitReset), .regAddr(regAddr), .selectAHi(sel[2]),
    .selectBHi(sel[1]), .selectCLo_n(sel[0]),
    .addrLatchStrobe_n(addrStrobe_n), .readStrobeHi(rdHi),
    .readStrobeLo_n(rdLo_n), .writeStrobeHi(wrHi),
    .writeStrobeLo_n(wrLo_n), .hostDataIn(busLevel),
    .hostDataOut(devData), .hostDataOe(devOe),
    .selectedIndicator(selInd), .driveDisable_n(drvDis_n),
    .regView(regView));
  uhbp_host_model i_uhbp_host_model (.clk(clk), .devData(devData),
    .devOe(devOe), .hostData(hostData), .hostOe(hostOe),
    .busLevel(busLevel));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic testDone();
    if (nErrors == 0 && nTests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    nTests++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", what, e, g);
      nErrors++;
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d, input bit hi);
    regAddr = a;
    hostData = d;
    hostOe = 1'b1;
    step(1);
    if (hi) wrHi = 1'b1;
    else wrLo_n = 1'b0;
    step(8);
    wrHi = 1'b0;
    wrLo_n = 1'b1;
    step(6);
    hostOe = 1'b0;
    step(1);
  endtask
  task automatic rd(input logic [2:0] a, input bit hi, input logic [7:0] e);
    int k;
    regAddr = a;
    step(1);
    if (hi) rdHi = 1'b1;
    else rdLo_n = 1'b0;
    for (k = 0; k < 12 && devOe !== 1'b1; k++) step(1);
    if (k == 12) begin
      $display("[FAIL] read drive expected 1 seen %b", devOe);
      nErrors++;
      testDone();
    end
    step(1);
    chk("read data", e, devData);
    chk("bus level", e, busLevel);
    chk("drive disable", 8'h00, {7'h0, drvDis_n});
    chk("indicator", 8'h01, {7'h0, selInd});
    rdHi = 1'b0;
    rdLo_n = 1'b1;
    step(8);
    chk("bus released", 8'h00, {7'h0, devOe});
    chk("drive disable idle", 8'h01, {7'h0, drvDis_n});
  endtask
  task automatic tReset();
    for (int i = 0; i < NUM_REGS; i++)
      chk("reset reg", 8'h00, regView[i]);
    chk("reset oe", 8'h00, {7'h0, devOe});
    chk("reset drive disable", 8'h01, {7'h0, drvDis_n});
  endtask
  task automatic tAccess();
    sel = 3'h6;
    wr(3'h5, 8'hA5, 1'b0);
    wr(3'h2, 8'h3C, 1'b1);
    wr(3'h7, 8'h01, 1'b0);
    chk("reg5", 8'hA5, regView[5]);
    chk("reg2", 8'h3C, regView[2]);
    chk("reg0", 8'h00, regView[0]);
    chk("lsb", 8'h01, {7'h0, regView[7][0]});
    rd(3'h5, 1'b0, 8'hA5);
    rd(3'h2, 1'b1, 8'h3C);
  endtask
  task automatic tUnselected();
    for (int i = 0; i < 8; i++) if (i != 6) begin
      sel = i[2:0];
      wr(3'h5, 8'hFF, i[0]);
      chk("unsel indicator", 8'h00, {7'h0, selInd});
      chk("unsel reg", 8'hA5, regView[5]);
      rdLo_n = 1'b0;
      step(8);
      chk("unsel oe", 8'h00, {7'h0, devOe});
      rdLo_n = 1'b1;
      step(6);
    end
  endtask
  task automatic tLatch();
    sel = 3'h6;
    regAddr = 3'h3;
    step(6);
    addrStrobe_n = 1'b0;
    step(6);
    sel = 3'h0;
    wr(3'h6, 8'h5A, 1'b0);
    chk("latched reg", 8'h5A, regView[3]);
    chk("live reg", 8'h00, regView[6]);
    addrStrobe_n = 1'b1;
    step(6);
  endtask
  task automatic tUnitReset();
    unitReset = 1'b1;
    step(8);
    unitReset = 1'b0;
    step(6);
    chk("unit reset reg5", 8'h00, regView[5]);
    chk("unit reset reg3", 8'h00, regView[3]);
  endtask
  task automatic tTiedLow();
    rst_n = 1'b0;
    addrStrobe_n = 1'b0;
    sel = 3'h6;
    step(2);
    rst_n = 1'b1;
    step(8);
    tReset();
    wr(3'h4, 8'hC3, 1'b1);
    chk("tied low reg4", 8'hC3, regView[4]);
    rd(3'h4, 1'b0, 8'hC3);
  endtask
  initial begin
    step(10);
    rst_n = 1'b1;
    step(8);
    tReset();
    tAccess();
    tUnselected();
    tLatch();
    tUnitReset();
    tTiedLow();
    testDone();
  end
endmodule
`default_nettype wire
